// File: pidv_params.svh
// Offsets, field positions, reset values and codes of the paged id and vendor registers
// Notes on behaviour
// - Writing 1 into the page select field shows the identification page in the paged window.
// - The identification page reads a fixed compliance level of 01h at its first paged address.
// - A fixed 24-bit maker identifier is read most significant byte first from paged address 1010b.
// - A fixed 24-bit part code is read most significant byte first from 1101b; 1001b is reserved.
// - Writing 7 into the page select field shows the vendor-dependent page in the paged window.
// - With the null-packet bit set, requests are cleared only by a received packet over 8 bits.
// - With the null-packet bit clear, requests are cleared by any received packet except an ack.
// - The null-packet bit is read-write, 0 after hardware reset, and kept over a bus reset.
// - The 2-bit link rate field is read-write: 00 S100, 01 S200, 10 S400, 11 illegal.
// - The link rate field is copied into the speed field of the transmitted self-ID packet.
// - Toward peer PHYs the device always advertises S400 whatever the link rate field holds.
// - Hardware reset loads the link rate field with 10b and a bus reset leaves it alone.
// - The board straps three power class pins whose value is the default self-ID power class.
// - The straps are captured after each hardware reset and a later register 4 write replaces them.
// - Power class codes are 000 none, 001-011 self-powered, 100/110/111 bus-powered, 101 reserved.
`ifndef PIDV_PARAMS_SVH
`define PIDV_PARAMS_SVH

// Register indices, byte address is four times the index
`define PIDV_IDX_PWR          4'h4
`define PIDV_IDX_PAGE         4'h7
`define PIDV_IDX_COMPLIANCE   4'h8
`define PIDV_IDX_ID_RSVD      4'h9
`define PIDV_IDX_OUI_HI       4'hA
`define PIDV_IDX_OUI_MID      4'hB
`define PIDV_IDX_OUI_LO       4'hC
`define PIDV_IDX_PART_HI      4'hD
`define PIDV_IDX_PART_MID     4'hE
`define PIDV_IDX_PART_LO      4'hF
`define PIDV_IDX_NULL_RATE    4'h8

// Page codes
`define PIDV_PAGE_IDENT       3'h1
`define PIDV_PAGE_VENDOR      3'h7
`define PIDV_PAGE_LSB         5

// Field positions in the vendor-dependent control byte and in the power class register
`define PIDV_NPA_BIT          7
`define PIDV_PWR_LSB          0

// Fixed values and reset values
`define PIDV_COMPLIANCE_VAL   8'h01
`define PIDV_RATE_RST         2'h2
`define PIDV_RATE_ILLEGAL     2'h3
`define PIDV_NPA_RST          1'b0
`define PIDV_PEER_S400        2'h2
`define PIDV_ACK_BITS         16'h0008
`define PIDV_STRAP_CAP_CNT    2'h2

`endif

// File: pidv_pkg.sv
// Types for the paged id and vendor register block
package pidv_pkg;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } pidv_apb_req_t;

  typedef struct packed {
    logic [1:0] link_sp;
    logic [2:0] pwr;
    logic [1:0] phy_sp;
  } pidv_selfid_t;

  typedef enum logic [1:0] {
    PIDV_CAP_WAIT = 2'b00,
    PIDV_CAP_DONE = 2'b01
  } pidv_cap_state_t;

endpackage

// File: pidv_regs.sv
// Paged id and vendor registers with APB slave, strap capture and request clearing
`timescale 1ns/100ps
`include "pidv_params.svh"

module pidv_regs #(
  parameter logic [23:0] MAKER_OUI = 24'h00_0001, // Arbitrary value
  parameter logic [23:0] PART_CODE = 24'h00_0002  // Arbitrary value
) (
  input  wire logic                  clock,
  input  wire logic                  rst_n,
  input  wire pidv_pkg::pidv_apb_req_t apb_req,
  output logic                       pready,
  output logic [31:0]                prdata,
  output logic                       pslverr,
  input  wire logic [2:0]            power_category_straps,
  input  wire logic                  rx_pkt_end,
  input  wire logic [15:0]           rx_pkt_bits,
  output logic                       arb_req_clear,
  output pidv_pkg::pidv_selfid_t     selfid
);

  logic [2:0]                  page_r;
  logic                        npa_r;
  logic [1:0]                  rate_r;
  logic [2:0]                  pwr_r;
  logic [2:0]                  strap_s1_r;
  logic [2:0]                  strap_s2_r;
  logic [1:0]                  cap_cnt_r;
  pidv_pkg::pidv_cap_state_t   cap_st_r;
  logic                        pready_r;
  logic [31:0]                 prdata_r;
  logic                        pslverr_r;
  logic                        clr_r;
  pidv_pkg::pidv_selfid_t      selfid_r;
  logic                        acc;
  logic                        wr;
  logic [3:0]                  idx;
  logic                        aligned;
  logic [7:0]                  rd_byte;
  logic                        mapped;
  logic                        pwr_wr;

  assign acc     = apb_req.psel & apb_req.penable & ~pready_r;
  assign wr      = acc & apb_req.pwrite;
  assign idx     = apb_req.paddr[5:2];
  assign aligned = (apb_req.paddr[11:6] == 6'h00) && (apb_req.paddr[1:0] == 2'b00);
  assign pwr_wr  = wr && aligned && (idx == `PIDV_IDX_PWR);

  // Read mux and address decode
  always_comb begin
    rd_byte = 8'h00;
    mapped  = aligned;
    case (idx)
      `PIDV_IDX_PWR:  rd_byte = {5'h00, pwr_r};
      `PIDV_IDX_PAGE: rd_byte = {page_r, 5'h00};
      4'h8, 4'h9, 4'hA, 4'hB, 4'hC, 4'hD, 4'hE, 4'hF: begin
        if (page_r == `PIDV_PAGE_IDENT) begin
          case (idx)
            `PIDV_IDX_COMPLIANCE: rd_byte = `PIDV_COMPLIANCE_VAL;
            `PIDV_IDX_OUI_HI:     rd_byte = MAKER_OUI[23:16];
            `PIDV_IDX_OUI_MID:    rd_byte = MAKER_OUI[15:8];
            `PIDV_IDX_OUI_LO:     rd_byte = MAKER_OUI[7:0];
            `PIDV_IDX_PART_HI:    rd_byte = PART_CODE[23:16];
            `PIDV_IDX_PART_MID:   rd_byte = PART_CODE[15:8];
            `PIDV_IDX_PART_LO:    rd_byte = PART_CODE[7:0];
            default:              rd_byte = 8'h00;
          endcase
        end else if (page_r == `PIDV_PAGE_VENDOR) begin
          if (idx == `PIDV_IDX_NULL_RATE) begin
            rd_byte = {npa_r, 5'h00, rate_r};
          end else begin
            rd_byte = 8'h00;
          end
        end else begin
          rd_byte = 8'h00;
        end
      end
      default: mapped = 1'b0;
    endcase
  end

  // APB answer, one wait state
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= acc;
      pslverr_r <= acc & ~mapped;
      if (acc && !apb_req.pwrite && mapped) begin
        prdata_r <= {24'h00_0000, rd_byte};
      end else begin
        prdata_r <= 32'h0000_0000;
      end
    end
  end

  // Page select
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      page_r <= 3'h0;
    end else if (wr && aligned && idx == `PIDV_IDX_PAGE) begin
      page_r <= apb_req.pwdata[`PIDV_PAGE_LSB +: 3];
    end
  end

  // Vendor-dependent controls, only hardware reset touches them
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      npa_r  <= `PIDV_NPA_RST;
      rate_r <= `PIDV_RATE_RST;
    end else if (wr && aligned && idx == `PIDV_IDX_NULL_RATE
                 && page_r == `PIDV_PAGE_VENDOR) begin
      npa_r <= apb_req.pwdata[`PIDV_NPA_BIT];
      if (apb_req.pwdata[1:0] != `PIDV_RATE_ILLEGAL) begin
        rate_r <= apb_req.pwdata[1:0];
      end
    end
  end

  // Strap synchroniser
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      strap_s1_r <= 3'h0;
      strap_s2_r <= 3'h0;
    end else begin
      strap_s1_r <= power_category_straps;
      strap_s2_r <= strap_s1_r;
    end
  end

  // Strap capture after reset release
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      cap_cnt_r <= 2'h0;
      cap_st_r  <= pidv_pkg::PIDV_CAP_WAIT;
    end else begin
      case (cap_st_r)
        pidv_pkg::PIDV_CAP_WAIT: begin
          if (cap_cnt_r == `PIDV_STRAP_CAP_CNT) begin
            cap_st_r <= pidv_pkg::PIDV_CAP_DONE;
          end else begin
            cap_cnt_r <= cap_cnt_r + 2'h1;
          end
        end
        pidv_pkg::PIDV_CAP_DONE: cap_st_r <= pidv_pkg::PIDV_CAP_DONE;
        default:                 cap_st_r <= pidv_pkg::PIDV_CAP_WAIT;
      endcase
    end
  end

  // Power class, register write wins over strap capture
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      pwr_r <= 3'h0;
    end else if (pwr_wr) begin
      pwr_r <= apb_req.pwdata[`PIDV_PWR_LSB +: 3];
    end else if (cap_st_r == pidv_pkg::PIDV_CAP_WAIT && cap_cnt_r == `PIDV_STRAP_CAP_CNT) begin
      pwr_r <= strap_s2_r;
    end
  end

  // Arbitration request clearing
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      clr_r <= 1'b0;
    end else if (rx_pkt_end) begin
      if (npa_r) begin
        clr_r <= (rx_pkt_bits > `PIDV_ACK_BITS);
      end else begin
        clr_r <= (rx_pkt_bits != `PIDV_ACK_BITS);
      end
    end else begin
      clr_r <= 1'b0;
    end
  end

  // Self-ID fields
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      selfid_r <= '0;
    end else begin
      selfid_r.link_sp <= rate_r;
      selfid_r.pwr     <= pwr_r;
      selfid_r.phy_sp  <= `PIDV_PEER_S400;
    end
  end

  assign pready        = pready_r;
  assign prdata        = prdata_r;
  assign pslverr       = pslverr_r;
  assign arb_req_clear = clr_r;
  assign selfid        = selfid_r;

endmodule

// File: pidv_monitor.sv
// Port checker for the paged id and vendor registers
`timescale 1ns/100ps
module pidv_monitor (
  input wire logic                    clock,
  input wire logic                    rst_n,
  input wire pidv_pkg::pidv_apb_req_t apb_req,
  input wire logic                    pready,
  input wire logic [31:0]             prdata,
  input wire logic                    pslverr,
  input wire logic [2:0]              power_category_straps,
  input wire logic                    rx_pkt_end,
  input wire logic [15:0]             rx_pkt_bits,
  input wire logic                    arb_req_clear,
  input wire pidv_pkg::pidv_selfid_t  selfid
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  AST_ANSWER: assert property (apb_req.psel && apb_req.penable && !pready |=> pready)
    else $error("no answer");
  AST_PULSE: assert property (pready |=> !pready)
    else $error("pready too long");
  AST_IDLE: assert property (!pready |-> prdata == 32'h0000_0000)
    else $error("prdata not idle");
  AST_UNMAPPED: assert property (apb_req.psel && apb_req.penable && !pready &&
    apb_req.paddr[5:4] == 2'h0 |=> pready && pslverr)
    else $error("no error on unmapped");
  AST_PEER: assert property ($past(rst_n) |-> selfid.phy_sp == 2'h2)
    else $error("peer speed wrong");
  AST_RATE: assert property ($past(rst_n) |-> selfid.link_sp != 2'h3)
    else $error("illegal rate");
  AST_LONG: assert property (rx_pkt_end && rx_pkt_bits > 16'h0008 |=> arb_req_clear)
    else $error("long packet kept");
  AST_ACK: assert property (rx_pkt_end && rx_pkt_bits == 16'h0008 |=> !arb_req_clear)
    else $error("ack cleared");
  AST_CAUSE: assert property (arb_req_clear |-> $past(rx_pkt_end))
    else $error("clear without packet");
endmodule

bind pidv_regs pidv_monitor u_pidv_monitor (.clock(clock), .rst_n(rst_n), .apb_req(apb_req),
  .pready(pready), .prdata(prdata), .pslverr(pslverr),
  .power_category_straps(power_category_straps), .rx_pkt_end(rx_pkt_end),
  .rx_pkt_bits(rx_pkt_bits), .arb_req_clear(arb_req_clear), .selfid(selfid));

// File: pidv_link_model.sv
// Link-side APB master model
`timescale 1ns/100ps
module pidv_link_model (
  input  wire logic                    clock,
  output pidv_pkg::pidv_apb_req_t      apb_req,
  input  wire logic                    pready,
  input  wire logic [31:0]             prdata,
  input  wire logic                    pslverr
);
  initial apb_req = '0;
  task automatic xfer(input logic w, input logic [3:0] i, input logic [7:0] d,
                      output logic [7:0] rd, output logic err);
    @(posedge clock);
    apb_req <= '{1'b1, 1'b0, w, {6'h00, i, 2'h0}, {24'h00_0000, d}};
    @(posedge clock);
    apb_req.penable <= 1'b1;
    do @(posedge clock); while (pready !== 1'b1);
    rd = prdata[7:0];
    err = pslverr;
    apb_req <= '0;
  endtask
endmodule

// File: tb.sv
// Testbench for the paged id and vendor registers
`timescale 1ns/100ps
module tb;
  localparam logic [23:0] OUI  = 24'h5A_3C96; // Arbitrary value
  localparam logic [23:0] PART = 24'hC3_1E87; // Arbitrary value
  logic                    clock = 1'b0;
  logic                    rst_n = 1'b0;
  logic [2:0]              straps = 3'h0;
  logic                    rx_end = 1'b0;
  logic [15:0]             rx_bits = 16'h0000;
  pidv_pkg::pidv_apb_req_t apb_req;
  logic                    pready;
  logic [31:0]             prdata;
  logic                    pslverr;
  logic                    arb_clr;
  pidv_pkg::pidv_selfid_t  selfid;
  logic [7:0]              rd;
  logic                    err;
  logic [15:0]             tab [4] = '{16'h0000, 16'h0007, 16'h0008, 16'h0009};
  int                      fail_count = 0;
  int                      total_checks = 0;
  int                      cycles = 0;
  pidv_regs #(.MAKER_OUI(OUI), .PART_CODE(PART)) u_pidv_regs (.clock(clock), .rst_n(rst_n),
    .apb_req(apb_req), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .power_category_straps(straps), .rx_pkt_end(rx_end), .rx_pkt_bits(rx_bits),
    .arb_req_clear(arb_clr), .selfid(selfid));
  pidv_link_model u_pidv_link_model (.clock(clock), .apb_req(apb_req), .pready(pready),
    .prdata(prdata), .pslverr(pslverr));
  initial forever #12.5 clock = ~clock;
  task automatic give_verdict;
    if (fail_count == 0 && total_checks > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      give_verdict;
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] want);
    total_checks++;
    if (got !== want) begin
      fail_count++;
      $display("[ERR] %0t got %h want %h", $time, got, want);
    end
  endtask
  task automatic rw(input logic w, input logic [3:0] i, input logic [7:0] d);
    u_pidv_link_model.xfer(w, i, d, rd, err);
  endtask
  task automatic pkt(input logic [15:0] b, input logic e);
    @(posedge clock);
    rx_end <= 1'b1;
    rx_bits <= b;
    @(posedge clock);
    rx_end <= 1'b0;
    @(negedge clock);
    chk({7'h00, arb_clr}, {7'h00, e});
  endtask
  task automatic t_power;
    for (int c = 0; c < 8; c++) begin
      straps <= c[2:0];
      rst_n <= 1'b0;
      repeat (8) @(posedge clock);
      rst_n <= 1'b1;
      repeat (6) @(posedge clock);
      chk({5'h00, selfid.pwr}, {5'h00, c[2:0]});
      chk({6'h00, selfid.link_sp}, 8'h02);
    end
    rw(1'b1, 4'h4, 8'h05);
    repeat (2) @(posedge clock);
    chk({5'h00, selfid.pwr}, 8'h05);
  endtask
  task automatic t_ident;
    logic [7:0] want [8];
    want = '{8'h01, 8'h00, OUI[23:16], OUI[15:8], OUI[7:0], PART[23:16], PART[15:8], PART[7:0]};
    rw(1'b1, 4'h7, 8'h20);
    rw(1'b1, 4'h8, 8'hFF);
    rw(1'b1, 4'hA, 8'hFF);
    for (int i = 0; i < 8; i++) begin
      rw(1'b0, 4'h8 + i[3:0], 8'h00);
      chk(rd, want[i]);
    end
    rw(1'b0, 4'h2, 8'h00);
    chk({7'h00, err}, 8'h01);
  endtask
  task automatic t_vendor;
    rw(1'b1, 4'h7, 8'hE0);
    rw(1'b0, 4'h8, 8'h00);
    chk(rd, 8'h02);
    rw(1'b1, 4'h8, 8'h81);
    rw(1'b0, 4'h8, 8'h00);
    chk(rd, 8'h81);
    chk({6'h00, selfid.link_sp}, 8'h01);
    chk({6'h00, selfid.phy_sp}, 8'h02);
    for (int i = 0; i < 4; i++) pkt(tab[i], i == 3);
    rw(1'b1, 4'h8, 8'h03);
    rw(1'b0, 4'h8, 8'h00);
    chk(rd, 8'h01);
    for (int i = 0; i < 4; i++) pkt(tab[i], i != 2);
    rw(1'b1, 4'h9, 8'hFF);
    rw(1'b0, 4'h9, 8'h00);
    chk(rd, 8'h00);
  endtask
  initial begin
    t_power;
    t_ident;
    t_vendor;
    give_verdict;
  end
endmodule
